// File: hdl/ulpi_regmap_pkg.sv
// Purpose: Shared constants and types for the transceiver register bank.
// Assumes: Byte-wide registers reached by a register access port on the interface clock.
// Notes:   Offsets are the immediate-space byte addresses.
package ulpi_regmap_pkg;

  localparam int DATA_W = 8;

  // -------------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MAKER_LO   = 8'h00;
  localparam logic [7:0] ADDR_MAKER_HI   = 8'h01;
  localparam logic [7:0] ADDR_PART_LO    = 8'h02;
  localparam logic [7:0] ADDR_PART_HI    = 8'h03;
  localparam logic [7:0] ADDR_LEVEL_VIEW = 8'h13;
  localparam logic [7:0] ADDR_CAPT_VIEW  = 8'h14;
  localparam logic [7:0] ADDR_LINE_DIAG  = 8'h15;
  localparam logic [7:0] ADDR_RSVD_LO    = 8'h19;
  localparam logic [7:0] ADDR_RSVD_HI    = 8'h2e;
  localparam logic [7:0] ADDR_GATEWAY    = 8'h2f;
  localparam logic [7:0] ADDR_SPEC_LO    = 8'h30;
  localparam logic [7:0] ADDR_SPEC_HI    = 8'h3c;
  localparam logic [7:0] ADDR_MIRROR_TOP = 8'h3f;
  localparam int         SPEC_COUNT      = 13;

  // Registers with read, write, set and clear addresses at base, +1, +2.
  localparam int NUM_RSC    = 7;
  localparam int IDX_FUNC   = 0;
  localparam int IDX_ALT    = 1;
  localparam int IDX_DUAL   = 2;
  localparam int IDX_RISE   = 3;
  localparam int IDX_FALL   = 4;
  localparam int IDX_SPARE  = 5;
  localparam int IDX_SUPPLY = 6;
  localparam logic [NUM_RSC-1:0][7:0] RSC_BASE = {8'h3d, 8'h16, 8'h10, 8'h0d, 8'h0a, 8'h07, 8'h04};
  localparam logic [NUM_RSC-1:0][7:0] RSC_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h41};
  localparam logic [7:0] OFS_SET   = 8'h01;
  localparam logic [7:0] OFS_CLEAR = 8'h02;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_SET, OP_CLEAR} wr_op_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acc_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } acc_rsp_t;

endpackage : ulpi_regmap_pkg

// File: hdl/rsc_byte.sv
// Purpose: One byte register with overwrite, bit-set and bit-clear updates.
// Assumes: Operation decoded by the caller, one operation per cycle.
// Notes:   Holds its reset value until the first write.
`timescale 1ns/1ps
module rsc_byte
  import ulpi_regmap_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire wr_op_t     op_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] q_o
);

  logic [7:0] q_d;

  always_comb begin
    case (op_i)
      OP_WRITE: q_d = data_i;
      OP_SET:   q_d = q_o | data_i;
      OP_CLEAR: q_d = q_o & ~data_i;
      default:  q_d = q_o;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= RESET_VAL;
    end else begin
      q_o <= q_d;
    end
  end

endmodule : rsc_byte

// File: hdl/ulpi_phy_register_map.sv
// Purpose: Register bank of a USB transceiver reached by link register accesses.
// Assumes: The interface front end presents one decoded access per cycle on ACC_I.
// Notes:   Read data returns one cycle after the access; writes take effect at the same edge.
`timescale 1ns/1ps

module ulpi_phy_register_map
  import ulpi_regmap_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h5aa5,  // Arbitrary value.
  parameter logic [15:0] PART_CODE  = 16'h3cc3,  // Arbitrary value.
  parameter int          EVENT_W    = 8
) (
  input  wire logic             CLK_I,
  input  wire logic             RESET_I,
  input  wire acc_req_t         ACC_I,
  input  wire logic [EVENT_W-1:0] EVENT_LEVEL_I,
  input  wire logic [7:0]       LINE_DIAG_I,
  output acc_rsp_t              RSP_O,
  output logic      [7:0]       FUNC_CTRL_O,
  output logic      [7:0]       ALT_CTRL_O,
  output logic      [7:0]       DUAL_CTRL_O,
  output logic      [7:0]       RISE_EN_O,
  output logic      [7:0]       FALL_EN_O,
  output logic      [7:0]       SUPPLY_CTRL_O,
  output logic      [7:0]       CAPTURE_O
);

  // -------------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------------
  generate
    if (EVENT_W != DATA_W) begin : g_bad_width
      $error("event width must equal the register width");
    end
  endgenerate

  typedef enum {GW_IDLE, GW_ARMED} gw_state_t;

  // -------------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------------
  function automatic wr_op_t decode_op(input logic [7:0] addr, input logic [7:0] base);
    wr_op_t op;
    op = OP_NONE;
    if (addr == base) begin
      op = OP_WRITE;
    end else if (addr == 8'(base + OFS_SET)) begin
      op = OP_SET;
    end else if (addr == 8'(base + OFS_CLEAR)) begin
      op = OP_CLEAR;
    end
    return op;
  endfunction : decode_op

  function automatic logic in_range(input logic [7:0] addr, input logic [7:0] lo, input logic [7:0] hi);
    return (addr >= lo) && (addr <= hi);
  endfunction : in_range

  // -------------------------------------------------------------------------
  // Input synchronisers for levels from the analog side
  // -------------------------------------------------------------------------
  logic [7:0] event_s1_q;
  logic [7:0] event_s2_q;
  logic [7:0] event_prev_q;
  logic [7:0] diag_s1_q;
  logic [7:0] diag_s2_q;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      event_s1_q   <= 8'h00;
      event_s2_q   <= 8'h00;
      event_prev_q <= 8'h00;
      diag_s1_q    <= 8'h00;
      diag_s2_q    <= 8'h00;
    end else begin
      event_s1_q   <= EVENT_LEVEL_I;
      event_s2_q   <= event_s1_q;
      event_prev_q <= event_s2_q;
      diag_s1_q    <= LINE_DIAG_I;
      diag_s2_q    <= diag_s1_q;
    end
  end

  // -------------------------------------------------------------------------
  // Extended-space gateway
  // -------------------------------------------------------------------------
  // The write to the gateway carries the extended address; the next access
  // then goes to that address. The gateway is only seen in immediate space,
  // so an extended access can never re-arm itself.
  gw_state_t  gw_state_q;
  gw_state_t  gw_state_d;
  logic [7:0] ext_addr_q;
  logic [7:0] ext_addr_d;

  wire logic       armed       = (gw_state_q == GW_ARMED);
  wire logic       gw_hit      = ACC_I.valid && ACC_I.write && !armed && (ACC_I.addr == ADDR_GATEWAY);
  wire logic [7:0] eff_addr    = armed ? ext_addr_q : ACC_I.addr;
  wire logic       ext_ok      = !armed || (ext_addr_q <= ADDR_MIRROR_TOP);
  wire logic       live        = ACC_I.valid && ext_ok && !gw_hit;
  wire logic       do_write    = live && ACC_I.write;
  wire logic       do_read     = live && !ACC_I.write;

  always_comb begin
    gw_state_d = gw_state_q;
    ext_addr_d = ext_addr_q;
    case (gw_state_q)
      GW_IDLE: begin
        if (gw_hit) begin
          gw_state_d = GW_ARMED;
          ext_addr_d = ACC_I.wdata;
        end
      end
      GW_ARMED: begin
        if (ACC_I.valid) begin
          gw_state_d = GW_IDLE;
        end
      end
      default: gw_state_d = GW_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      gw_state_q <= GW_IDLE;
      ext_addr_q <= 8'h00;
    end else begin
      gw_state_q <= gw_state_d;
      ext_addr_q <= ext_addr_d;
    end
  end

  // -------------------------------------------------------------------------
  // Read, write, set and clear registers
  // -------------------------------------------------------------------------
  logic [NUM_RSC-1:0][7:0] rsc_q;
  logic [NUM_RSC-1:0][7:0] rsc_rd;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RSC; gi++) begin : g_rsc
      wire wr_op_t op = do_write ? decode_op(eff_addr, RSC_BASE[gi]) : OP_NONE;

      rsc_byte #(
        .RESET_VAL (RSC_RESET[gi])
      ) u_cell (
        .clk_i  (CLK_I),
        .rst_i  (RESET_I),
        .op_i   (op),
        .data_i (ACC_I.wdata),
        .q_o    (rsc_q[gi])
      );

      assign rsc_rd[gi] = in_range(eff_addr, RSC_BASE[gi], 8'(RSC_BASE[gi] + OFS_CLEAR)) ? rsc_q[gi] : 8'h00;
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Maker-specific bytes, plain overwrite storage
  // -------------------------------------------------------------------------
  logic [7:0] spec_q [SPEC_COUNT];

  wire logic       spec_hit = in_range(eff_addr, ADDR_SPEC_LO, ADDR_SPEC_HI);
  wire logic [3:0] spec_idx = 4'(eff_addr - ADDR_SPEC_LO);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < SPEC_COUNT; i++) begin
        spec_q[i] <= 8'h00;
      end
    end else if (do_write && spec_hit) begin
      spec_q[spec_idx] <= ACC_I.wdata;
    end
  end

  // -------------------------------------------------------------------------
  // Event capture
  // -------------------------------------------------------------------------
  // A read of the capture byte clears it, but an edge seen in that same
  // cycle is kept so no event slips between read and clear.
  logic [7:0] capture_q;
  logic [7:0] capture_d;

  wire logic [7:0] rise_ev  = event_s2_q & ~event_prev_q & rsc_q[IDX_RISE];
  wire logic [7:0] fall_ev  = ~event_s2_q & event_prev_q & rsc_q[IDX_FALL];
  wire logic       capt_rd  = do_read && (eff_addr == ADDR_CAPT_VIEW);

  assign capture_d = (capt_rd ? 8'h00 : capture_q) | rise_ev | fall_ev;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      capture_q <= 8'h00;
    end else begin
      capture_q <= capture_d;
    end
  end

  // -------------------------------------------------------------------------
  // Read data selection
  // -------------------------------------------------------------------------
  // Reserved, gateway and out-of-map reads return zero; no write reaches
  // anything outside the decoded cells, maker bytes and gateway.
  logic [7:0] rsc_any;

  always_comb begin
    rsc_any = 8'h00;
    for (int i = 0; i < NUM_RSC; i++) begin
      rsc_any = rsc_any | rsc_rd[i];
    end
  end

  wire logic [7:0] rd_fixed =
      (eff_addr == ADDR_MAKER_LO)   ? MAKER_CODE[7:0]  :
      (eff_addr == ADDR_MAKER_HI)   ? MAKER_CODE[15:8] :
      (eff_addr == ADDR_PART_LO)    ? PART_CODE[7:0]   :
      (eff_addr == ADDR_PART_HI)    ? PART_CODE[15:8]  :
      (eff_addr == ADDR_LEVEL_VIEW) ? event_s2_q       :
      (eff_addr == ADDR_CAPT_VIEW)  ? capture_q        :
      (eff_addr == ADDR_LINE_DIAG)  ? diag_s2_q        : 8'h00;
  wire logic [7:0] rd_spec = spec_hit ? spec_q[spec_idx] : 8'h00;
  wire logic       rsvd    = in_range(eff_addr, ADDR_RSVD_LO, ADDR_RSVD_HI);
  wire logic [7:0] rd_data = rsvd ? 8'h00 : (rd_fixed | rd_spec | rsc_any);

  acc_rsp_t rsp_d;

  assign rsp_d.valid = ACC_I.valid && !ACC_I.write;
  assign rsp_d.data  = ext_ok ? rd_data : 8'h00;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      RSP_O <= '0;
    end else begin
      RSP_O <= rsp_d;
    end
  end

  assign FUNC_CTRL_O   = rsc_q[IDX_FUNC];
  assign ALT_CTRL_O    = rsc_q[IDX_ALT];
  assign DUAL_CTRL_O   = rsc_q[IDX_DUAL];
  assign RISE_EN_O     = rsc_q[IDX_RISE];
  assign FALL_EN_O     = rsc_q[IDX_FALL];
  assign SUPPLY_CTRL_O = rsc_q[IDX_SUPPLY];
  assign CAPTURE_O     = capture_q;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  // Extended checks key on the gateway state, not on the address field, because
  // an armed access carries an address that the bank ignores.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  wire logic imm_wr = ACC_I.valid && ACC_I.write && !armed;
  wire logic imm_rd = ACC_I.valid && !ACC_I.write && !armed;
  wire logic ro_addr = (ACC_I.addr <= ADDR_PART_HI) || in_range(ACC_I.addr, ADDR_LEVEL_VIEW, ADDR_LINE_DIAG)
                       || in_range(ACC_I.addr, ADDR_RSVD_LO, ADDR_RSVD_HI);

  a_write_replace: assert property (
    imm_wr && ACC_I.addr == RSC_BASE[IDX_FUNC] |=> FUNC_CTRL_O == $past(ACC_I.wdata))
    else $error("overwrite did not store the presented byte");

  a_set_merge: assert property (
    imm_wr && ACC_I.addr == 8'(RSC_BASE[IDX_ALT] + OFS_SET)
    |=> ALT_CTRL_O == ($past(ALT_CTRL_O) | $past(ACC_I.wdata)))
    else $error("set address did not OR the byte in");

  a_clear_mask: assert property (
    imm_wr && ACC_I.addr == 8'(RSC_BASE[IDX_DUAL] + OFS_CLEAR)
    |=> DUAL_CTRL_O == ($past(DUAL_CTRL_O) & ~$past(ACC_I.wdata)))
    else $error("clear address did not mask the register");

  a_ro_stable: assert property (
    imm_wr && ro_addr |=> $stable(rsc_q) && capture_q == ($past(capture_q) | $past(rise_ev | fall_ev)))
    else $error("write to read-only or reserved address changed state");

  a_rise_alias: assert property (
    imm_rd && ACC_I.addr == 8'(RSC_BASE[IDX_RISE] + OFS_CLEAR) |=> RSP_O.valid && RSP_O.data == RISE_EN_O)
    else $error("rising enable not readable at its clear address");

  a_fall_alias: assert property (
    imm_rd && ACC_I.addr == 8'(RSC_BASE[IDX_FALL] + OFS_SET) |=> RSP_O.valid && RSP_O.data == FALL_EN_O)
    else $error("falling enable not readable at its set address");

  a_level_read: assert property (
    imm_rd && ACC_I.addr == ADDR_LEVEL_VIEW |=> RSP_O.data == $past(event_s2_q))
    else $error("event level read wrong");

  a_capture_clear: assert property (
    imm_rd && ACC_I.addr == ADDR_CAPT_VIEW ##0 (rise_ev | fall_ev) == 8'h00
    |=> RSP_O.data == $past(capture_q) && capture_q == 8'h00)
    else $error("capture byte not returned and cleared on read");

  a_rsvd_zero: assert property (
    imm_rd && in_range(ACC_I.addr, ADDR_RSVD_LO, ADDR_RSVD_HI) |=> RSP_O.valid && RSP_O.data == 8'h00)
    else $error("reserved read returned data");

  a_gateway_arm: assert property (
    imm_wr && ACC_I.addr == ADDR_GATEWAY |=> armed && ext_addr_q == $past(ACC_I.wdata) && $stable(rsc_q))
    else $error("gateway write did not arm the extended access");

  a_ext_mirror: assert property (
    ACC_I.valid && ACC_I.write && armed && ext_addr_q == RSC_BASE[IDX_FALL]
    |=> rsc_q[IDX_FALL] == $past(ACC_I.wdata) && !armed)
    else $error("extended write did not reach the mirrored register");

  a_ext_ignored: assert property (
    ACC_I.valid && armed && ext_addr_q > ADDR_MIRROR_TOP |=> $stable(rsc_q) && RSP_O.data == 8'h00)
    else $error("reserved extended access had an effect");

  a_id_codes: assert property (
    imm_rd && ACC_I.addr == ADDR_MAKER_HI ##1 imm_rd && ACC_I.addr == ADDR_PART_LO
    |-> RSP_O.data == MAKER_CODE[15:8] ##1 RSP_O.data == PART_CODE[7:0])
    else $error("identification bytes wrong");

  a_read_inert: assert property (
    ACC_I.valid && !ACC_I.write |=> $stable(rsc_q))
    else $error("a read changed a register");

  a_ext_read: assert property (
    ACC_I.valid && !ACC_I.write && armed && ext_addr_q == ADDR_MAKER_HI |=> RSP_O.valid && RSP_O.data == MAKER_CODE[15:8])
    else $error("extended read did not mirror the maker byte");

  c_ext_write:   cover property (imm_wr && ACC_I.addr == ADDR_GATEWAY ##1 ACC_I.valid && ACC_I.write);
  c_ext_read:    cover property (ACC_I.valid && !ACC_I.write && armed);
  c_capture_set: cover property ((rise_ev | fall_ev) != 8'h00 ##[1:20] capt_rd);
  c_set_clear:   cover property (imm_wr && ACC_I.addr == 8'h0e ##[1:5] imm_wr && ACC_I.addr == 8'h0f);

endmodule : ulpi_phy_register_map

// File: verif/link_model.sv
// Purpose: Behavioural link controller that issues register accesses to the bank.
// Assumes: One access per cycle, launched by non-blocking assignment at the rising edge.
// Notes:   Idle cycles carry random address and data so that the valid bit alone must gate the bank.
`timescale 1ns/1ps
module link_model
  import ulpi_regmap_pkg::*;
(
  input  wire logic clk_i,
  output acc_req_t  acc_o
);
  initial acc_o = '0;

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    acc_o <= '{valid: 1'b1, write: wr, addr: addr, wdata: data};
  endtask : access

  // Ends a burst; the short delay lets the taking edge's updates land before anyone looks.
  task automatic idle();
    @(posedge clk_i);
    acc_o <= '{valid: 1'b0, write: 1'b1, addr: 8'($urandom), wdata: 8'($urandom)};
    #1;
  endtask : idle

  // The gateway write carries the far address; the next access's own address is noise.
  task automatic far_access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    access(1'b1, ADDR_GATEWAY, addr & 8'h3f);
    access(wr, 8'($urandom), data);
  endtask : far_access
endmodule : link_model

// File: verif/ulpi_phy_register_map_tb.sv
// Purpose: Self-checking bench for the transceiver register bank.
// Assumes: Read data appears one cycle after the taking edge; writes land at that edge.
// Notes:   Expected read bytes wait in a queue until the response monitor consumes them.
`timescale 1ns/1ps
module ulpi_phy_register_map_tb;
  import ulpi_regmap_pkg::*;

  localparam logic [15:0] MAKER = 16'h9be1; // Arbitrary value.
  localparam logic [15:0] PART  = 16'h27d8; // Arbitrary value.

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic [7:0]              event_level = 8'h00;
  logic [7:0]              line_diag = 8'h00;
  acc_req_t                acc;
  acc_rsp_t                rsp;
  logic [7:0]              func, alt, dual, rise, fall, supply, capture;
  logic [NUM_RSC-1:0][7:0] outs;
  logic [7:0]              exp_q[$];
  int                      n_errors = 0;
  int                      n_checks = 0;

  assign outs = {supply, 8'h00, fall, rise, dual, alt, func};

  always #5 clk = ~clk;

  link_model link_u (.clk_i(clk), .acc_o(acc));

  ulpi_phy_register_map #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut_u (
    .CLK_I(clk), .RESET_I(rst), .ACC_I(acc), .EVENT_LEVEL_I(event_level), .LINE_DIAG_I(line_diag),
    .RSP_O(rsp), .FUNC_CTRL_O(func), .ALT_CTRL_O(alt), .DUAL_CTRL_O(dual), .RISE_EN_O(rise),
    .FALL_EN_O(fall), .SUPPLY_CTRL_O(supply), .CAPTURE_O(capture)
  );

  // ---------------------------------------------------------------------------
  // Response monitor and helpers
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    logic [7:0] e;
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, rsp.data, 8'h00);
      end else begin
        e = exp_q.pop_front();
        `CHK(rsp.data, e)
      end
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    link_u.access(1'b0, a, 8'($urandom));
  endtask : rd

  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  initial begin
    #50000;
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0]              w, s, c, v, base;
    logic [NUM_RSC-1:0][7:0] snap;
    void'($urandom(38857));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) rd(8'h04 + 8'(k), 8'h41);
    rd(ADDR_MAKER_LO, MAKER[7:0]);
    rd(ADDR_MAKER_HI, MAKER[15:8]);
    rd(ADDR_PART_LO, PART[7:0]);
    rd(ADDR_PART_HI, PART[15:8]);
    // Overwrite, set and clear back to back on every three-address register.
    for (int i = 0; i < NUM_RSC; i++) begin
      base = RSC_BASE[i];
      w = 8'($urandom);
      s = 8'($urandom);
      c = 8'($urandom);
      v = (w | s) & ~c;
      link_u.access(1'b1, base, w);
      rd(base, w);
      link_u.access(1'b1, base + OFS_SET, s);
      rd(base + OFS_SET, w | s);
      link_u.access(1'b1, base + OFS_CLEAR, c);
      for (int k = 0; k < 3; k++) rd(base + 8'(k), v);
      link_u.idle();
      if (i != IDX_SPARE) `CHK(outs[i], v)
    end
    base = ADDR_SPEC_LO + 8'($urandom_range(SPEC_COUNT - 1));
    w = 8'($urandom);
    link_u.access(1'b1, base, w);
    rd(base, w);
    // Writes aimed at read-only and reserved places must leave everything alone.
    link_u.idle();
    snap = outs;
    for (int k = 0; k < 'h2f; k++)
      if (k < 4 || (k >= 'h13 && k <= 'h15) || k >= 'h19) link_u.access(1'b1, 8'(k), 8'($urandom));
    for (int k = 'h19; k <= 'h2e; k++) rd(8'(k), 8'h00);
    rd(ADDR_GATEWAY, 8'h00);
    rd(ADDR_MAKER_LO, MAKER[7:0]);
    rd(ADDR_PART_HI, PART[15:8]);
    link_u.idle();
    `CHK(outs, snap)
    `CHK(capture, 8'h00)
    // Far space reaches the same registers through the gateway.
    w = 8'($urandom);
    link_u.far_access(1'b1, RSC_BASE[IDX_FALL], w);
    exp_q.push_back(w);
    link_u.far_access(1'b0, RSC_BASE[IDX_FALL] + OFS_CLEAR, 8'h00);
    exp_q.push_back(MAKER[15:8]);
    link_u.far_access(1'b0, ADDR_MAKER_HI, 8'h00);
    link_u.idle();
    `CHK(fall, w)
    // Rising edges captured where enabled, falling edges dropped where disabled; a read of the capture byte empties it.
    link_u.access(1'b1, RSC_BASE[IDX_RISE], 8'hff);
    link_u.access(1'b1, RSC_BASE[IDX_FALL], 8'h00);
    link_u.idle();
    v = 8'($urandom) | 8'h01;
    @(posedge clk);
    event_level <= v;
    line_diag <= ~v;
    repeat (6) @(posedge clk);
    #1;
    `CHK(capture, v)
    rd(ADDR_LEVEL_VIEW, v);
    rd(ADDR_LINE_DIAG, ~v);
    rd(ADDR_CAPT_VIEW, v);
    rd(ADDR_CAPT_VIEW, 8'h00);
    link_u.idle();
    @(posedge clk);
    event_level <= 8'h00;
    repeat (6) @(posedge clk);
    rd(ADDR_CAPT_VIEW, 8'h00);
    // A second reset in mid-run brings the reset values back.
    link_u.idle();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(RSC_BASE[IDX_FUNC], 8'h41);
    rd(RSC_BASE[IDX_RISE], 8'h00);
    link_u.idle();
    repeat (3) @(posedge clk);
    `CHK(exp_q.size(), 0)
    finish_test();
  end
endmodule : ulpi_phy_register_map_tb
